// >>> inc/fxm_defs.vh
// Constants of the fixed-point multiply unit: register map, fields, codes.
// Included by the multiply unit; definitions only.
`ifndef FXM_DEFS_VH
`define FXM_DEFS_VH

// Register byte offsets on the bus
`define FXM_OFS_INSN     8'h00
`define FXM_OFS_SRCA_LO  8'h04
`define FXM_OFS_SRCA_HI  8'h08
`define FXM_OFS_SRCB_LO  8'h0C
`define FXM_OFS_SRCB_HI  8'h10
`define FXM_OFS_CTRL     8'h14
`define FXM_OFS_RES_LO   8'h18
`define FXM_OFS_RES_HI   8'h1C
`define FXM_OFS_TARGET   8'h20
`define FXM_OFS_CR0      8'h24
`define FXM_OFS_XER      8'h28
`define FXM_OFS_IRQ_STAT 8'h2C
`define FXM_OFS_IRQ_MASK 8'h30
`define FXM_OFS_STATUS   8'h34

// Control register fields
`define FXM_CTRL_START   0
`define FXM_CTRL_MODE64  1

// Condition field zero layout {lt, gt, eq, sticky}
`define FXM_CR_LT        3
`define FXM_CR_GT        2
`define FXM_CR_EQ        1
`define FXM_CR_SO        0

// Exception register layout {sticky, too wide, carry}
`define FXM_XER_SO       2
`define FXM_XER_OV       1
`define FXM_XER_CA       0

// Interrupt status and mask layout
`define FXM_IRQ_DONE     0
`define FXM_IRQ_ILLEGAL  1
`define FXM_IRQ_OVERFLOW 2

// Instruction fields and codes
`define FXM_PRIM_MSB     31
`define FXM_PRIM_LSB     26
`define FXM_XO_MSB       9
`define FXM_XO_LSB       1
`define FXM_OE_BIT       10
`define FXM_RC_BIT       0
`define FXM_PRIM_X       6'd31
`define FXM_PRIM_IMM     6'd7
`define FXM_XO_HWU       9'd11
`define FXM_XO_LD        9'd233
`define FXM_XO_LW        9'd235

// Reset values
`define FXM_RST_CTRL     2'h2
`define FXM_RST_XER      3'h0

`endif

// >>> logic/fxm_mul_unit.v
// Fixed-point multiply unit: decodes and runs four multiply forms,
// writes the target register and updates condition field and exceptions.
// Assumes a classic Wishbone master on clk_sys and a register file that
// takes the target write port; all inputs are synchronous to clk_sys.
`timescale 1ns/10ps
`include "fxm_defs.vh"

module fxm_mul_unit #(
	parameter IMPL64 = 1
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         irq_o,
	output reg         target_we_o,
	output reg  [4:0]  target_gpr_o,
	output reg  [63:0] target_data_o,
	output reg         illegal_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	localparam K_NONE = 3'd0;
	localparam K_HWU  = 3'd1;
	localparam K_LD   = 3'd2;
	localparam K_IMM  = 3'd3;
	localparam K_LW   = 3'd4;

	reg        state_q;
	reg [31:0] insn_q;
	reg [63:0] src_a_q;
	reg [63:0] src_b_q;
	reg [1:0]  ctrl_q;
	reg [63:0] res_q;
	reg [4:0]  tgt_q;
	reg [3:0]  cr0_q;
	reg [2:0]  xer_q;
	reg [2:0]  irq_stat_q;
	reg [2:0]  irq_mask_q;

	// Byte-lane merge for partial writes
	function [31:0] fxm_merge;
		input [31:0] old;
		input [31:0] new_val;
		input [3:0]  sel;
		integer i;
		begin
			fxm_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i])
					fxm_merge[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
	endfunction

	// Signed compare against zero: {lt, gt, eq}
	function [2:0] fxm_cmp0;
		input [63:0] v;
		input        wide;
		reg   [63:0] w;
		begin
			w = wide ? v : {{32{v[31]}}, v[31:0]};
			fxm_cmp0 = {w[63], ~w[63] & (|w), ~(|w)};
		end
	endfunction

	// Decode
	wire [5:0] prim  = insn_q[`FXM_PRIM_MSB:`FXM_PRIM_LSB];
	wire [8:0] xo    = insn_q[`FXM_XO_MSB:`FXM_XO_LSB];
	wire       oe    = insn_q[`FXM_OE_BIT];
	wire       rc    = insn_q[`FXM_RC_BIT];
	wire [4:0] rt    = insn_q[25:21];
	wire [15:0] simm = insn_q[15:0];
	reg  [2:0] kind;

	// Bit numbers above count from the LSB: bits 22-30 big-endian are xo
	always @* begin
		kind = K_NONE;
		if (prim == `FXM_PRIM_IMM)
			kind = K_IMM;
		else if (prim == `FXM_PRIM_X) begin
			case (xo)
				`FXM_XO_HWU: kind = K_HWU;
				`FXM_XO_LD:  kind = (IMPL64 != 0) ? K_LD : K_NONE;
				`FXM_XO_LW:  kind = K_LW;
				default:     kind = K_NONE;
			endcase
		end
	end

	// One shared signed 65x65 multiplier; operands extended per form
	reg signed [64:0] op_a;
	reg signed [64:0] op_b;
	always @* begin
		case (kind)
			K_HWU: begin
				op_a = {33'h0, src_a_q[31:0]};
				op_b = {33'h0, src_b_q[31:0]};
			end
			K_LD: begin
				op_a = {src_a_q[63], src_a_q};
				op_b = {src_b_q[63], src_b_q};
			end
			K_IMM: begin
				op_a = {{33{src_a_q[31]}}, src_a_q[31:0]};
				op_b = {{49{simm[15]}}, simm};
			end
			default: begin
				op_a = {{33{src_a_q[31]}}, src_a_q[31:0]};
				op_b = {{33{src_b_q[31]}}, src_b_q[31:0]};
			end
		endcase
	end

	wire signed [129:0] prod = op_a * op_b;

	reg  [63:0] res_d;
	reg         ovf;
	always @* begin
		res_d = 64'h0;
		ovf   = 1'b0;
		case (kind)
			K_HWU: res_d = {32'h0, prod[63:32]};
			K_LD: begin
				res_d = prod[63:0];
				// Full 64-bit check whatever the mode
				ovf = prod[127:64] != {64{prod[63]}};
			end
			K_IMM: res_d = {32'h0, prod[31:0]};
			K_LW: begin
				res_d = {32'h0, prod[31:0]};
				ovf   = prod[63:32] != {32{prod[31]}};
			end
			default: res_d = 64'h0;
		endcase
	end

	// Exception and condition updates
	reg [2:0] xer_d;
	reg [3:0] cr0_d;
	reg [2:0] flags;
	always @* begin
		xer_d = xer_q;
		cr0_d = cr0_q;
		flags = 3'h0;
		case (kind)
			K_HWU: flags = fxm_cmp0(res_d, 1'b0);
			// Mode picks the compare width; flags follow truncated value
			K_LD:  flags = fxm_cmp0(res_d, ctrl_q[`FXM_CTRL_MODE64]);
			K_LW:  flags = fxm_cmp0(res_d, 1'b0);
			default: flags = 3'h0;
		endcase
		if ((kind == K_LD || kind == K_LW) && oe) begin
			// Carry bit deliberately left alone
			xer_d[`FXM_XER_OV] = ovf;
			if (ovf)
				xer_d[`FXM_XER_SO] = 1'b1;
		end
		if ((kind == K_HWU || kind == K_LD || kind == K_LW) && rc)
			cr0_d = {flags, xer_d[`FXM_XER_SO]};
		// Immediate form falls through with both untouched
	end

	wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr   = bus_req & wb_we_i;
	wire start_wr = bus_wr && wb_adr_i == `FXM_OFS_CTRL && wb_sel_i[0] &&
	                wb_dat_i[`FXM_CTRL_START] && state_q == ST_IDLE;
	wire exec     = state_q == ST_EXEC;
	wire illegal  = exec && kind == K_NONE;

	reg [2:0] irq_set;
	reg [2:0] irq_clr;
	always @* begin
		irq_set = 3'h0;
		irq_set[`FXM_IRQ_DONE]     = exec;
		irq_set[`FXM_IRQ_ILLEGAL]  = illegal;
		irq_set[`FXM_IRQ_OVERFLOW] = exec && oe && ovf;
		irq_clr = 3'h0;
		if (bus_wr && wb_adr_i == `FXM_OFS_IRQ_STAT && wb_sel_i[0])
			irq_clr = wb_dat_i[2:0];
	end

	// Register read mux
	reg [31:0] rd_d;
	always @* begin
		case (wb_adr_i)
			`FXM_OFS_INSN:     rd_d = insn_q;
			`FXM_OFS_SRCA_LO:  rd_d = src_a_q[31:0];
			`FXM_OFS_SRCA_HI:  rd_d = src_a_q[63:32];
			`FXM_OFS_SRCB_LO:  rd_d = src_b_q[31:0];
			`FXM_OFS_SRCB_HI:  rd_d = src_b_q[63:32];
			`FXM_OFS_CTRL:     rd_d = {30'h0, ctrl_q[1], 1'b0};
			`FXM_OFS_RES_LO:   rd_d = res_q[31:0];
			`FXM_OFS_RES_HI:   rd_d = res_q[63:32];
			`FXM_OFS_TARGET:   rd_d = {27'h0, tgt_q};
			`FXM_OFS_CR0:      rd_d = {28'h0, cr0_q};
			`FXM_OFS_XER:      rd_d = {29'h0, xer_q};
			`FXM_OFS_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
			`FXM_OFS_IRQ_MASK: rd_d = {29'h0, irq_mask_q};
			`FXM_OFS_STATUS:   rd_d = {31'h0, state_q};
			default:           rd_d = 32'h0;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q       <= ST_IDLE;
			insn_q        <= 32'h0;
			src_a_q       <= 64'h0;
			src_b_q       <= 64'h0;
			ctrl_q        <= `FXM_RST_CTRL;
			res_q         <= 64'h0;
			tgt_q         <= 5'h0;
			cr0_q         <= 4'h0;
			xer_q         <= `FXM_RST_XER;
			irq_stat_q    <= 3'h0;
			irq_mask_q    <= 3'h0;
			wb_ack_o      <= 1'b0;
			wb_dat_o      <= 32'h0;
			irq_o         <= 1'b0;
			target_we_o   <= 1'b0;
			target_gpr_o  <= 5'h0;
			target_data_o <= 64'h0;
			illegal_o     <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_d : 32'h0;
			// Operand writes are refused while a multiply is running
			if (bus_wr && state_q == ST_IDLE) begin
				case (wb_adr_i)
					`FXM_OFS_INSN:
						insn_q <= fxm_merge(insn_q, wb_dat_i, wb_sel_i);
					`FXM_OFS_SRCA_LO:
						src_a_q[31:0] <= fxm_merge(src_a_q[31:0], wb_dat_i, wb_sel_i);
					`FXM_OFS_SRCA_HI:
						src_a_q[63:32] <= fxm_merge(src_a_q[63:32], wb_dat_i, wb_sel_i);
					`FXM_OFS_SRCB_LO:
						src_b_q[31:0] <= fxm_merge(src_b_q[31:0], wb_dat_i, wb_sel_i);
					`FXM_OFS_SRCB_HI:
						src_b_q[63:32] <= fxm_merge(src_b_q[63:32], wb_dat_i, wb_sel_i);
					`FXM_OFS_CTRL:
						if (wb_sel_i[0])
							ctrl_q[`FXM_CTRL_MODE64] <= wb_dat_i[`FXM_CTRL_MODE64];
					`FXM_OFS_CR0:
						if (wb_sel_i[0])
							cr0_q <= wb_dat_i[3:0];
					`FXM_OFS_XER:
						if (wb_sel_i[0])
							xer_q <= wb_dat_i[2:0];
					`FXM_OFS_IRQ_MASK:
						if (wb_sel_i[0])
							irq_mask_q <= wb_dat_i[2:0];
					default: ;
				endcase
			end
			// Set wins over a same-cycle clear
			irq_stat_q  <= (irq_stat_q & ~irq_clr) | irq_set;
			irq_o       <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
			target_we_o <= 1'b0;
			illegal_o   <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start_wr)
						state_q <= ST_EXEC;
				end
				ST_EXEC: begin
					state_q <= ST_IDLE;
					if (illegal) begin
						illegal_o <= 1'b1;
					end else begin
						res_q         <= res_d;
						tgt_q         <= rt;
						target_we_o   <= 1'b1;
						target_gpr_o  <= rt;
						target_data_o <= res_d;
						xer_q         <= xer_d;
						cr0_q         <= cr0_d;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // fxm_mul_unit

// >>> bench/fxm_gpr_model.sv
// Register-file side of the multiply unit: keeps every target write.
// Assumes the write port is valid on the clk_sys edge that sees target_we high.
`timescale 1ns/10ps
module fxm_gpr_model (
	input wire        clk_sys,
	input wire        we,
	input wire [4:0]  idx,
	input wire [63:0] data
);
	logic [63:0] gpr_q [0:31];
	// Never reset, so a missed write stays unknown and fails its compare
	always @(posedge clk_sys) begin
		if (we) begin
			gpr_q[idx] <= data;
		end
	end
endmodule // fxm_gpr_model

// >>> bench/fxm_mul_unit_asserts.sv
// Port timing checker of the multiply unit.
// Bound to every fxm_mul_unit; sees its ports only.
`timescale 1ns/10ps
module fxm_mul_unit_chk (
	input wire        clk_sys,
	input wire        rst_n,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        target_we_o,
	input wire [63:0] target_data_o,
	input wire        illegal_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire go   = take & wb_we_i & (wb_adr_i == 8'h14) & wb_sel_i[0] & wb_dat_i[0];
	property p_ack; take |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_dat0; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat0: assert property (p_dat0) else $error("read data without ack");
	property p_start; go |-> ##2 (target_we_o | illegal_o); endproperty
	a_start: assert property (p_start) else $error("start not executed");
	property p_cause; (target_we_o | illegal_o) |-> $past(go, 2); endproperty
	a_cause: assert property (p_cause) else $error("result without start");
	property p_excl; !(target_we_o & illegal_o); endproperty
	a_excl: assert property (p_excl) else $error("write on illegal");
	property p_pulse; target_we_o |=> !target_we_o; endproperty
	a_pulse: assert property (p_pulse) else $error("write strobe too long");
	property p_hold; !target_we_o |-> $stable(target_data_o); endproperty
	a_hold: assert property (p_hold) else $error("result moved");
endmodule // fxm_mul_unit_chk

bind fxm_mul_unit fxm_mul_unit_chk i_fxm_mul_unit_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.target_we_o(target_we_o), .target_data_o(target_data_o), .illegal_o(illegal_o));

// >>> bench/fxm_mul_unit_tb.sv
// Self-checking bench of the multiply unit, one task per scenario.
// Drives classic Wishbone; the register-file model takes target writes.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module fxm_mul_unit_tb;
	logic        clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, seen_ill;
	logic [7:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] wdat = 0, q;
	wire  [31:0] rdat;
	wire         ack, irq, twe, ill;
	wire  [4:0]  tidx;
	wire  [63:0] tdat;
	int          n_errors = 0, tests_run = 0, ncyc = 0;
	always #5 clk_sys = ~clk_sys;
	fxm_mul_unit #(.IMPL64(1)) i_fxm_mul_unit (.clk_sys(clk_sys), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .target_we_o(twe),
		.target_gpr_o(tidx), .target_data_o(tdat), .illegal_o(ill));
	fxm_gpr_model i_fxm_gpr_model (.clk_sys(clk_sys), .we(twe), .idx(tidx), .data(tdat));
	function [31:0] x(input [4:0] t, input oe, input [8:0] xo, input rc);
		x = {6'h1F, t, 10'h0, oe, xo, rc};
	endfunction
	task wb(input [7:0] a, input w, input [31:0] d);
		@(posedge clk_sys);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do @(posedge clk_sys); while (ack !== 1'h1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] e, input string nm);
		wb(a, 0, 0);
		`CHK(nm, e, q)
	endtask
	// Operands go in as word pairs, then the start bit with the mode
	task ex(input [31:0] ins, input [63:0] a, input [63:0] b, input [31:0] ctl);
		wb(8'h00, 1, ins);
		wb(8'h04, 1, a[31:0]);
		wb(8'h08, 1, a[63:32]);
		wb(8'h0C, 1, b[31:0]);
		wb(8'h10, 1, b[63:32]);
		wb(8'h14, 1, ctl);
		repeat (8) begin
			@(posedge clk_sys);
			if (twe === 1'h1 || ill === 1'h1) break;
		end
		seen_ill = ill;
		// Let the register-file model take the write before it is read
		@(posedge clk_sys);
	endtask
	task t_reset;
		rd(8'h14, 32'h2, "ctrl");
		rd(8'h28, 32'h0, "xer");
		rd(8'h3C, 32'h0, "unmapped");
	endtask
	task t_hwu;
		ex(x(5'h6, 0, 9'h00B, 1), 64'hFFFFFFFF, 64'hFFFFFFFF, 32'h3);
		`CHK("hwu", 64'hFFFFFFFE, i_fxm_gpr_model.gpr_q[6])
		rd(8'h24, 32'h8, "cr0 hwu");
	endtask
	task t_lw;
		wb(8'h28, 1, 32'h1);
		wb(8'h30, 1, 32'h4);
		ex(x(5'h7, 1, 9'h0EB, 1), 64'h4500, 64'h7FFFFFFF, 32'h3);
		`CHK("lw", 64'hFFFFBB00, i_fxm_gpr_model.gpr_q[7])
		rd(8'h24, 32'h9, "cr0 lw");
		rd(8'h28, 32'h7, "xer lw");
		rd(8'h2C, 32'h5, "irq stat");
		`CHK("irq on", 1'h1, irq)
		wb(8'h2C, 1, 32'h7);
		rd(8'h2C, 32'h0, "irq cleared");
		`CHK("irq off", 1'h0, irq)
	endtask
	task t_imm;
		ex({6'h07, 5'h9, 5'h4, 16'hFFF6}, 64'h3000, 64'h0, 32'h3);
		`CHK("imm", 64'hFFFE2000, i_fxm_gpr_model.gpr_q[9])
		rd(8'h24, 32'h9, "cr0 imm");
		rd(8'h28, 32'h7, "xer imm");
	endtask
	task t_ld;
		wb(8'h28, 1, 32'h0);
		// Narrow mode still judges overflow on the full width
		ex(x(5'hC, 1, 9'h0E9, 1), 64'h100000000, 64'h100000000, 32'h1);
		`CHK("ld ovf", 64'h0, i_fxm_gpr_model.gpr_q[12])
		rd(8'h24, 32'h3, "cr0 ld");
		rd(8'h28, 32'h6, "xer ld");
		ex(x(5'hD, 1, 9'h0E9, 0), 64'hFFFFFFFFFFFFFFFE, 64'h3, 32'h3);
		`CHK("ld signed", 64'hFFFFFFFFFFFFFFFA, i_fxm_gpr_model.gpr_q[13])
		rd(8'h28, 32'h4, "xer ld fit");
	endtask
	task t_ill;
		wb(8'h2C, 1, 32'h7);
		ex(32'h0, 64'h0, 64'h0, 32'h3);
		`CHK("illegal", 1'h1, seen_ill)
		rd(8'h3C, 32'h0, "unmapped");
		`CHK("irq masked", 1'h0, irq)
		wb(8'h30, 1, 32'h2);
		rd(8'h3C, 32'h0, "unmapped");
		`CHK("irq illegal", 1'h1, irq)
	endtask
	task give_verdict;
		$display("errors %0d in %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		ncyc++;
		if (ncyc == 3000) begin
			n_errors++;
			give_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1;
		t_reset;
		t_hwu;
		t_lw;
		t_imm;
		t_ld;
		t_ill;
		give_verdict;
	end
endmodule // fxm_mul_unit_tb
